/* File: rtl/sar_map.svh */
// Purpose: constants for the converter readout logic
// Assumes: 25 MHz system clock
// Notes: times in ns, cycle counts derived from them
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
`define SAR_CLK_NS 40
`define SAR_CONV_MIN_NS 500
`define SAR_CONV_MAX_NS 1600
// longest time rounds down
`define SAR_CONV_CYC (`SAR_CONV_MAX_NS / `SAR_CLK_NS)
`define SAR_RES_BITS 16
`define SAR_CODE_MAX 16'hffff
`define SAR_CODE_MIN 16'h0000
`endif

/* File: rtl/sar_pkg.sv */
// Purpose: types for the converter readout logic
// Assumes: nothing
// Notes: constants live in sar_map.svh
package sar_pkg;
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_CONV = 2'b01,
        SAR_READ = 2'b10
    } sar_state_e;
    typedef struct packed {
        logic convertStart;
        logic serialClk;
        logic serialChainIn;
    } sar_pins_s;
endpackage

/* File: rtl/sar_adc_serial_readout.sv */
// Purpose: conversion start and serial readout of a 16-bit converter
// Assumes: host pins asynchronous to clk, sampled through two flops
// Notes: result delivered as a sample word plus over/under range flags
// Notes on behaviour
// - only convert rising edge starts conversion
// - serial input low at edge: chain mode
// - serial input high at edge: select mode
// - select mode: output enabled while convert low
// - select mode: either input low enables output
// - select low at completion enables busy indicator
// - serial clock shifts result out when selected
// - chain: input reappears sixteen clocks later
// - chain: serial input is cascade data
// - result readable right after conversion
// - data ready within maximum conversion time
// - internal clock converts; serial clock only reads
// - saturate code on over or under range
`timescale 1ns/10ps
`include "sar_map.svh"
module sar_adc_serial_readout
    import sar_pkg::*;
#(
    parameter int RES_BITS = `SAR_RES_BITS,
    parameter int CONV_CYC = `SAR_CONV_CYC
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convertStart,
    input wire logic serialClk,
    input wire logic serialChainIn,
    input wire logic [RES_BITS-1:0] sampleCode,
    input wire logic overRange,
    input wire logic underRange,
    output logic serialResultOut,
    output logic serialResultOutEn_b,
    output logic busy
);
    // the shifter and the bit counter are sized for sixteen bits
    if (RES_BITS != 16)
    begin : g_bad_width
        $error("unsupported result width");
    end
    // the conversion counter is eight bits wide
    if (CONV_CYC < 1 || CONV_CYC > 255)
    begin : g_bad_time
        $error("unsupported conversion length");
    end

    sar_pins_s pinRaw;
    wire sar_pins_s pinSync;
    wire sar_pins_s pinLast;
    sar_state_e state;
    logic chainMode;
    logic [7:0] convCount;
    logic [RES_BITS-1:0] shiftReg;
    logic [RES_BITS-1:0] loadCode;
    logic [4:0] bitCount;
    logic selectLow;
    logic cnvRise;
    logic sckFall;
    logic convDone;
    logic shiftEn;

    assign pinRaw = {convertStart, serialClk, serialChainIn};

    // first stage feeds only the second; one chain of flops per host pin
    for (genvar g = 0; g < $bits(sar_pins_s); g++)
    begin : g_sync
        logic meta;
        logic sync;
        logic last;
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                meta <= 1'b0;
                sync <= 1'b0;
                last <= 1'b0;
            end
            else
            begin
                meta <= pinRaw[g];
                sync <= meta;
                last <= sync;
            end
        end
        assign pinSync[g] = sync;
        assign pinLast[g] = last;
    end

    assign cnvRise = pinSync.convertStart && !pinLast.convertStart;
    assign sckFall = !pinSync.serialClk && pinLast.serialClk;
    assign selectLow = !pinSync.convertStart || !pinSync.serialChainIn;
    // completes at the max time, never later
    assign convDone = (state == SAR_CONV) && (convCount == 8'(CONV_CYC - 1));
    // select mode stops after the last bit; chain mode keeps passing data
    assign shiftEn = (state == SAR_READ) && sckFall
        && (chainMode || (selectLow && bitCount != 5'h10));

    // conversion timing runs on clk alone, serial clock not needed;
    // a convert rise during conversion is dropped, not queued
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= SAR_IDLE;
        else
        begin
            case (state)
                SAR_IDLE:
                begin
                    if (cnvRise)
                        state <= SAR_CONV;
                end
                SAR_CONV:
                begin
                    if (convDone)
                        state <= SAR_READ;
                end
                SAR_READ:
                begin
                    // result stays readable until the next convert edge
                    if (cnvRise)
                        state <= SAR_CONV;
                end
                default:
                    state <= SAR_IDLE;
            endcase
        end
    end

    // counter restarts with every accepted convert edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            convCount <= 8'h00;
        else if (state != SAR_CONV)
            convCount <= 8'h00;
        else
            convCount <= convCount + 8'h01;
    end

    // mode is fixed at the convert edge and held for the whole cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            chainMode <= 1'b0;
        else if (cnvRise && state != SAR_CONV)
            chainMode <= !pinSync.serialChainIn;
    end

    // saturation picks the code that the shifter loads at completion
    always_comb
    begin
        loadCode = sampleCode;
        if (overRange)
            loadCode = `SAR_CODE_MAX;
        else if (underRange)
            loadCode = `SAR_CODE_MIN;
    end

    // result load at completion, shift on serial clock falling edges
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            shiftReg <= '0;
        else if (convDone)
            shiftReg <= loadCode;
        else if (shiftEn)
        begin
            // chain input enters at lsb so it emerges 16 clocks later
            shiftReg <= {shiftReg[RES_BITS-2:0], pinSync.serialChainIn};
        end
    end

    // counts bits sent so select mode stops at the last one
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            bitCount <= 5'h00;
        else if (convDone)
            bitCount <= 5'h00;
        else if (shiftEn && bitCount != 5'h10)
            bitCount <= bitCount + 5'h01;
    end

    // busy follows the state one clock late, like the other outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            busy <= 1'b0;
        else
            busy <= (state == SAR_CONV);
    end

    // chain mode always drives, since reads happen with convert high;
    // select mode drives only while either pin is low
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            serialResultOutEn_b <= 1'b1;
        else if (chainMode)
            serialResultOutEn_b <= 1'b0;
        else if (selectLow)
            serialResultOutEn_b <= 1'b0;
        else
            serialResultOutEn_b <= 1'b1;
    end

    // low while converting doubles as busy indicator; msb once done
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            serialResultOut <= 1'b0;
        else if (state == SAR_CONV)
            serialResultOut <= 1'b0;
        else if (chainMode || selectLow)
            serialResultOut <= shiftReg[RES_BITS-1];
        else
            serialResultOut <= 1'b0;
    end
endmodule

/* File: testbench/sar_rd_props.sv */
// Purpose: readout timing checks
// Assumes: bound to the readout top
// Notes: n counts busy cycles
`timescale 1ns/10ps
module sar_rd_props #(parameter int CONV_CYC = 40)(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic convertStart,
    input wire logic serialResultOut,
    input wire logic serialResultOutEn_b,
    input wire logic busy
);
    int n;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            n <= 0;
        else
            n <= busy ? n + 1 : 0;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_start;
        $rose(busy) |-> $past(convertStart, 2);
    endproperty
    a_start: assert property (p_start) else $error("busy without convert");
    property p_len;
        $fell(busy) |-> n inside {[CONV_CYC - 2:CONV_CYC + 1]};
    endproperty
    a_len: assert property (p_len) else $error("bad conversion length");
    sequence s_accept;
        $rose(convertStart) && !busy;
    endsequence
    sequence s_busyRun;
        busy [*8];
    endsequence
    property p_accept;
        s_accept |-> ##[3:5] $rose(busy);
    endproperty
    a_accept: assert property (p_accept) else $error("convert edge not taken");
    property p_run;
        $rose(busy) |-> s_busyRun;
    endproperty
    a_run: assert property (p_run) else $error("conversion cut short");
    property p_enable;
        !convertStart [*4] |-> !serialResultOutEn_b;
    endproperty
    a_enable: assert property (p_enable) else $error("output not enabled");
    property p_busyOut;
        busy && !serialResultOutEn_b |-> !serialResultOut;
    endproperty
    a_busyOut: assert property (p_busyOut) else $error("busy indicator not low");
endmodule
bind sar_adc_serial_readout sar_rd_props #(.CONV_CYC(CONV_CYC)) sar_rd_props_inst (
    .clk(clk), .rst_b(rst_b), .convertStart(convertStart),
    .serialResultOut(serialResultOut), .serialResultOutEn_b(serialResultOutEn_b),
    .busy(busy));

/* File: testbench/sar_host.sv */
// Purpose: host side: convert, serial clock, chain data
// Assumes: serial clock period 8 clk, still between reads
// Notes: pins change just after clk rises
`timescale 1ns/10ps
module sar_host
    import sar_pkg::*;
(
    input wire logic clk,
    input wire logic resultIn,
    output sar_pins_s pins = '0
);
    task automatic setPins(input logic convert_start, input logic serial_chain_in);
        pins.convertStart <= convert_start;
        pins.serialChainIn <= serial_chain_in;
        repeat (5) @(posedge clk);
    endtask
    task automatic start(input logic chain);
        setPins(1'b0, !chain);
        setPins(1'b1, !chain);
        if (!chain)
            setPins(1'b0, 1'b1);
    endtask
    // convert is left alone, so chain reads keep it high
    task automatic shift(input logic [15:0] din, output logic [15:0] dout);
        for (int i = 15; i >= 0; i--)
        begin
            pins.serialClk <= 1'b1;
            pins.serialChainIn <= din[i];
            repeat (4) @(posedge clk);
            dout[i] = resultIn;
            pins.serialClk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the readout block
// Assumes: conversion shortened to 16 clk
// Notes: ana packs under, over and code
`timescale 1ns/10ps
`define CHK(g, w) begin checked++; if ((g) !== (w)) begin mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, g, w); end end
module tb_top
    import sar_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [17:0] ana = '0;
    logic serial_result_out, sdoEn_b, busy;
    sar_pins_s pins;
    int mismatches = 0, checked = 0;
    sar_adc_serial_readout #(.CONV_CYC(16)) sar_adc_serial_readout_inst (.clk(clk),
        .rst_b(rst_b), .convertStart(pins.convertStart), .serialClk(pins.serialClk),
        .serialChainIn(pins.serialChainIn), .sampleCode(ana[15:0]), .overRange(ana[16]),
        .underRange(ana[17]), .serialResultOut(serial_result_out), .serialResultOutEn_b(sdoEn_b),
        .busy(busy));
    // a released line reads inverted, never a stale level
    sar_host sar_host_inst (.clk(clk), .resultIn(sdoEn_b ? !serial_result_out : serial_result_out), .pins(pins));
    task automatic summarize();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic waitDone();
        for (int i = 0; busy !== 1'b0; i++)
            if (i < 99)
                @(posedge clk);
            else
            begin
                mismatches++;
                summarize();
            end
        repeat (3) @(posedge clk);
    endtask
    task automatic testSelect(input logic [17:0] a, input logic [15:0] want);
        logic [15:0] got;
        ana <= a;
        sar_host_inst.start(1'b0);
        `CHK({sdoEn_b, serial_result_out, busy}, 3'b001)
        waitDone();
        sar_host_inst.shift(16'h0000, got);
        `CHK(got, want)
        sar_host_inst.setPins(1'b1, 1'b1);
        `CHK({sdoEn_b, busy}, 2'b11)
        sar_host_inst.setPins(1'b1, 1'b0);
        `CHK(sdoEn_b, 1'b0)
        waitDone();
        $display("select test done");
    endtask
    task automatic testChain();
        logic [15:0] got;
        ana <= 18'h11234;
        sar_host_inst.start(1'b1);
        waitDone();
        sar_host_inst.shift(16'h5a0f, got);
        `CHK(got, 16'hffff)
        sar_host_inst.shift(16'h0000, got);
        `CHK(got, 16'h5a0f)
        $display("chain test done");
    endtask
    initial
    begin
        forever #20 clk = ~clk;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        testSelect(18'h0a5c3, 16'ha5c3);
        testSelect(18'h21234, 16'h0000);
        testChain();
        summarize();
    end
endmodule
